// ==== bench/carkit_otg_session_id_state_timing_regs_bench.sv ====
// self-checking bench for the carkit status and timing registers
`timescale 1ns/100ps
module carkit_otg_session_id_state_timing_regs_bench;
	localparam int TICK = 4; // short tick keeps timer runs brief
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr_en = 1'b0;
	logic reg_rd_en = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic reg_rd_valid;
	logic power_down_mode = 1'b0;
	logic rx_pulse_en = 1'b0;
	logic disconnect_then_connect_flag = 1'b0;
	logic [2:0] id_kind = 3'h2; // accessory present through reset
	logic [1:0] vbus_level = 2'h0; // supply below session end
	logic [1:0] line_state = 2'h1; // plus line high
	logic irq_low = 1'b0;
	logic rxd_idle = 1'b0;
	logic rx_polarity_recovered;
	logic vbus_below_b_session_end_flag, id_rdn_102k, id_rdn_440k, id_rdn_200k, id_open, id_grounded;
	logic minus_line_high, plus_line_high, session_valid, bus_supply_valid, carkit_irq_pin_low, rxd_idle_level;
	int err_count = 0;
	int cmp_count = 0;
	logic [7:0] rd_byte;

	carkit_otg_session_id_state_timing_regs #(.TICK_CYCLES(TICK)) u_carkit_otg_session_id_state_timing_regs (
		.ref_clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
		.power_down_mode, .rx_pulse_en, .disconnect_then_connect_flag, .vbus_below_b_session_end_flag,
		.id_rdn_102k, .id_rdn_440k, .id_rdn_200k, .id_open, .id_grounded, .minus_line_high,
		.plus_line_high, .session_valid, .bus_supply_valid, .carkit_irq_pin_low, .rxd_idle_level,
		.rx_polarity_recovered);

	connector_model u_connector_model (
		.id_kind, .vbus_level, .line_state, .irq_low, .rxd_idle, .vbus_below_b_session_end_flag,
		.id_rdn_102k, .id_rdn_440k, .id_rdn_200k, .id_open, .id_grounded, .minus_line_high,
		.plus_line_high, .session_valid, .bus_supply_valid, .carkit_irq_pin_low, .rxd_idle_level);

	// 25 MHz clock
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end

	// byte comparison
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// single bit comparison
	task automatic chk1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// wait n edges, then step off the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// one write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		cyc(1);
		reg_wr_en = 1'b0;
	endtask

	// one read strobe; answer is due one cycle later
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		#1;
		reg_rd_en = 1'b1;
		reg_addr = a;
		cyc(1);
		reg_rd_en = 1'b0;
		chk1(reg_rd_valid, 1'b1);
		rd_byte = reg_rdata;
	endtask

	// write, then read the same place in the very next cycle
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		cyc(1);
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b1;
		cyc(1);
		reg_rd_en = 1'b0;
		chk1(reg_rd_valid, 1'b1);
		rd_byte = reg_rdata;
	endtask

	// read and compare a register
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk8(rd_byte, exp);
	endtask

	// expected status byte from connector conditions
	function automatic logic [7:0] otg_exp(input logic [2:0] k, input logic [1:0] v);
		otg_exp = {1'b0, v == 2'h0, 2'h0, k == 3'h2, k == 3'h3, k == 3'h4, 1'b0};
	endfunction

	// expected source byte from connector conditions
	function automatic logic [7:0] src_exp(input logic [2:0] k, input logic [1:0] v, input logic [1:0] l,
		input logic i, input logic d);
		src_exp = {i, d, k == 3'h0, l[1], k == 3'h1, l[0], v != 2'h0, v == 2'h2};
	endfunction

	// print counts and the verdict, then stop
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// hang guard, well beyond the expected run
	initial begin
		repeat (3000) @(posedge ref_clk);
		err_count++;
		give_verdict();
	end

	// test sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		cyc(8);
		// reset values and pin-derived status
		rdc(8'h1E, 8'h64);
		rdc(8'h1F, 8'hC8);
		rdc(8'h10, 8'h48);
		rdc(8'h08, 8'h04);
		$display("test reset done");
		// read-write, read-only and unmapped places
		wr_rd(8'h1E, 8'hA5);
		chk8(rd_byte, 8'hA5);
		wr(8'h1F, 8'h00);
		rdc(8'h1F, 8'h00);
		wr(8'h10, 8'hFF);
		wr(8'h08, 8'hFF);
		rdc(8'h10, 8'h48);
		rdc(8'h08, 8'h04);
		rdc(8'h3C, 8'h00);
		$display("test access done");
		// every id kind against every supply level
		for (int k = 0; k < 5; k++) begin
			for (int v = 0; v < 3; v++) begin
				id_kind = 3'(k);
				vbus_level = 2'(v);
				line_state = 2'(k + v);
				disconnect_then_connect_flag = 1'(v);
				cyc(5);
				rdc(8'h10, otg_exp(3'(k), 2'(v)));
				rdc(8'h08, src_exp(3'(k), 2'(v), 2'(k + v), 1'b0, 1'(v)));
			end
		end
		$display("test status table done");
		// zero detect time, then power down
		id_kind = 3'h2;
		vbus_level = 2'h0;
		line_state = 2'h3;
		disconnect_then_connect_flag = 1'b1;
		irq_low = 1'b1;
		cyc(5);
		rdc(8'h10, 8'h48);
		rdc(8'h08, 8'hD4);
		power_down_mode = 1'b1;
		cyc(2);
		rdc(8'h10, 8'h00);
		rdc(8'h08, 8'h54);
		power_down_mode = 1'b0;
		irq_low = 1'b0;
		$display("test power down done");
		// programmed detect time of five ticks
		wr(8'h1F, 8'h05);
		irq_low = 1'b1;
		cyc(8);
		rd(8'h08);
		chk1(rd_byte[7], 1'b0);
		cyc(20);
		rd(8'h08);
		chk1(rd_byte[7], 1'b1);
		irq_low = 1'b0;
		cyc(5);
		rd(8'h08);
		chk1(rd_byte[7], 1'b0);
		$display("test detect delay done");
		// polarity recovery of three ticks
		wr(8'h1E, 8'h03);
		rxd_idle = 1'b1;
		cyc(30);
		chk1(rx_polarity_recovered, 1'b0);
		rx_pulse_en = 1'b1;
		cyc(3);
		chk1(rx_polarity_recovered, 1'b0);
		cyc(20);
		chk1(rx_polarity_recovered, 1'b1);
		rx_pulse_en = 1'b0;
		cyc(2);
		chk1(rx_polarity_recovered, 1'b0);
		$display("test recovery done");
		give_verdict();
	end
endmodule

// ==== bench/connector_model.sv ====
// connector side model: id resistor, supply level and line states
`timescale 1ns/100ps
module connector_model (
	input wire logic [2:0] id_kind,
	input wire logic [1:0] vbus_level,
	input wire logic [1:0] line_state,
	input wire logic irq_low,
	input wire logic rxd_idle,
	output logic vbus_below_b_session_end_flag,
	output logic id_rdn_102k,
	output logic id_rdn_440k,
	output logic id_rdn_200k,
	output logic id_open,
	output logic id_grounded,
	output logic minus_line_high,
	output logic plus_line_high,
	output logic session_valid,
	output logic bus_supply_valid,
	output logic carkit_irq_pin_low,
	output logic rxd_idle_level
);
	// id kind: 0 open, 1 grounded, 2 accessory, 3 high r charger, 4 mid r charger
	// supply level: 0 below session end, 1 session valid, 2 bus valid
	always_comb begin
		id_open = (id_kind == 3'h0);
		id_grounded = (id_kind == 3'h1);
		id_rdn_102k = (id_kind == 3'h2);
		id_rdn_440k = (id_kind == 3'h3);
		id_rdn_200k = (id_kind == 3'h4);
		vbus_below_b_session_end_flag = (vbus_level == 2'h0);
		session_valid = (vbus_level != 2'h0);
		bus_supply_valid = (vbus_level == 2'h2);
		plus_line_high = line_state[0];
		minus_line_high = line_state[1];
		carkit_irq_pin_low = irq_low;
		rxd_idle_level = rxd_idle;
	end
endmodule

// ==== verilog/carkit_otg_session_id_state_timing_regs.sv ====
// status and timing registers of the otg carkit transceiver
`timescale 1ns/100ps
module carkit_otg_session_id_state_timing_regs #(
	parameter int TICK_CYCLES = carkit_pkg::TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	// register port from the serial host interface
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rd_valid,
	// control levels from on-chip logic, same clock
	input wire logic power_down_mode,
	input wire logic rx_pulse_en,
	input wire logic disconnect_then_connect_flag,
	// comparator levels from the connector side, asynchronous
	input wire logic vbus_below_b_session_end_flag,
	input wire logic id_rdn_102k,
	input wire logic id_rdn_440k,
	input wire logic id_rdn_200k,
	input wire logic id_open,
	input wire logic id_grounded,
	input wire logic minus_line_high,
	input wire logic plus_line_high,
	input wire logic session_valid,
	input wire logic bus_supply_valid,
	input wire logic carkit_irq_pin_low,
	input wire logic rxd_idle_level,
	// data during audio receive polarity recovered
	output logic rx_polarity_recovered
);
	// positions of the comparator levels in the pin vector
	localparam int PIN_SESS_END = 0;
	localparam int PIN_ID_ACCESSORY_FLAG = 1;
	localparam int PIN_ID_CHARGER_HIGH_R_FLAG = 2;
	localparam int PIN_ID_CHARGER_MID_R_FLAG = 3;
	localparam int PIN_ID_OPEN = 4;
	localparam int PIN_ID_GROUNDED_FLAG = 5;
	localparam int PIN_MINUS_HI = 6;
	localparam int PIN_PLUS_HI = 7;
	localparam int PIN_SESSION_VALID_FLAG = 8;
	localparam int PIN_BUS_VLD = 9;
	localparam int PIN_IRQ_LOW = 10;
	localparam int PIN_RXD_IDLE = 11;

	logic rst_meta_reg; // reset release, first stage
	logic rst_sync_reg; // reset release, second stage
	logic rst_sync_n; // synchronised reset for the design
	logic [carkit_pkg::PIN_COUNT-1:0] pin_raw; // unsynchronised pin levels
	logic [carkit_pkg::PIN_COUNT-1:0] pin_meta_reg; // first synchroniser stage
	logic [carkit_pkg::PIN_COUNT-1:0] pin_sync_reg; // second synchroniser stage
	logic [7:0] rx_recovery_reg; // recovery time in ticks
	logic [7:0] rx_recovery_next;
	logic [7:0] carkit_irq_detect_value_reg; // irq detect time in ticks
	logic [7:0] carkit_irq_detect_value_next;
	logic [7:0] otg_session_id_state_reg; // otg session and id status
	logic [7:0] otg_session_id_state_next;
	logic [7:0] irq_source_reg; // live interrupt source state
	logic [7:0] irq_source_next;
	logic [7:0] rdata_reg; // read data
	logic [7:0] rdata_next;
	logic rd_valid_reg; // read answer strobe
	logic rd_valid_next;
	logic recovered_reg; // recovery output
	logic recovered_next;
	logic tick; // quarter millisecond tick
	logic carkit_irq_source; // carkit irq hold detected
	logic recovery_done; // rxd idle held for recovery time
	logic recovery_hold; // hold condition for the recovery timer

	// reset is asserted at once and released through two stages
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rst_sync_n = rst_sync_reg;

	// gather comparator levels
	assign pin_raw[PIN_SESS_END] = vbus_below_b_session_end_flag;
	assign pin_raw[PIN_ID_ACCESSORY_FLAG] = id_rdn_102k;
	assign pin_raw[PIN_ID_CHARGER_HIGH_R_FLAG] = id_rdn_440k;
	assign pin_raw[PIN_ID_CHARGER_MID_R_FLAG] = id_rdn_200k;
	assign pin_raw[PIN_ID_OPEN] = id_open;
	assign pin_raw[PIN_ID_GROUNDED_FLAG] = id_grounded;
	assign pin_raw[PIN_MINUS_HI] = minus_line_high;
	assign pin_raw[PIN_PLUS_HI] = plus_line_high;
	assign pin_raw[PIN_SESSION_VALID_FLAG] = session_valid;
	assign pin_raw[PIN_BUS_VLD] = bus_supply_valid;
	assign pin_raw[PIN_IRQ_LOW] = carkit_irq_pin_low;
	assign pin_raw[PIN_RXD_IDLE] = rxd_idle_level;

	// two stage synchroniser for each pin level
	genvar gi;
	generate
		for (gi = 0; gi < carkit_pkg::PIN_COUNT; gi++) begin : g_pin_sync
			always_ff @(posedge ref_clk or negedge rst_sync_n) begin
				if (!rst_sync_n) begin
					pin_meta_reg[gi] <= 1'b0;
					pin_sync_reg[gi] <= 1'b0;
				end else begin
					pin_meta_reg[gi] <= pin_raw[gi];
					pin_sync_reg[gi] <= pin_meta_reg[gi];
				end
			end
		end
	endgenerate

	// shared tick, stands in for the audio data clock
	tick_divider #(
		.TICK_CYCLES(TICK_CYCLES),
		.CNT_WIDTH(16)
	) u_tick (
		.ref_clk(ref_clk),
		.rst_sync_n(rst_sync_n),
		.tick(tick)
	);

	// carkit irq must stay low for the detect time
	low_hold_timer u_irq_timer (
		.ref_clk(ref_clk),
		.rst_sync_n(rst_sync_n),
		.tick(tick),
		.hold_level(pin_sync_reg[PIN_IRQ_LOW] && !power_down_mode),
		.limit(carkit_irq_detect_value_reg),
		.detected(carkit_irq_source)
	);

	// recovery timer only runs with receive enabled
	assign recovery_hold = rx_pulse_en && pin_sync_reg[PIN_RXD_IDLE];

	low_hold_timer u_recovery_timer (
		.ref_clk(ref_clk),
		.rst_sync_n(rst_sync_n),
		.tick(tick),
		.hold_level(recovery_hold),
		.limit(rx_recovery_reg),
		.detected(recovery_done)
	);

	// timing register writes; other addresses are ignored
	always_comb begin
		rx_recovery_next = rx_recovery_reg;
		carkit_irq_detect_value_next = carkit_irq_detect_value_reg;
		if (reg_wr_en) begin
			case (reg_addr)
				carkit_pkg::ADDR_RX_RECOVERY: begin
					rx_recovery_next = reg_wdata;
				end
				carkit_pkg::ADDR_IRQ_DETECT: begin
					carkit_irq_detect_value_next = reg_wdata;
				end
				default: begin
					// read only or unmapped, write dropped
				end
			endcase
		end
	end

	// status bytes built from synchronised pin levels and the disconnect_then_connect_flag control level
	always_comb begin
		otg_session_id_state_next = 8'h00; // reserved bits read zero
		irq_source_next = 8'h00;
		if (!power_down_mode) begin
			// flags forced low in power down
			otg_session_id_state_next[carkit_pkg::OTG_B_SESSION_END_FLAG_BIT] = pin_sync_reg[PIN_SESS_END];
			otg_session_id_state_next[carkit_pkg::OTG_ID_ACCESSORY_BIT] = pin_sync_reg[PIN_ID_ACCESSORY_FLAG];
			otg_session_id_state_next[carkit_pkg::OTG_ID_HIGH_R_BIT] = pin_sync_reg[PIN_ID_CHARGER_HIGH_R_FLAG];
			otg_session_id_state_next[carkit_pkg::OTG_ID_MID_R_BIT] = pin_sync_reg[PIN_ID_CHARGER_MID_R_FLAG];
			irq_source_next[carkit_pkg::SRC_ID_GROUNDED_FLAG_BIT] = pin_sync_reg[PIN_ID_GROUNDED_FLAG];
			irq_source_next[carkit_pkg::SRC_CARKIT_IRQ_BIT] = carkit_irq_source;
		end
		// live mirror of the remaining signals
		irq_source_next[carkit_pkg::SRC_DISC_CONN_BIT] = disconnect_then_connect_flag;
		irq_source_next[carkit_pkg::SRC_ID_OPEN_BIT] = pin_sync_reg[PIN_ID_OPEN];
		irq_source_next[carkit_pkg::SRC_MINUS_HIGH_BIT] = pin_sync_reg[PIN_MINUS_HI];
		irq_source_next[carkit_pkg::SRC_PLUS_HIGH_BIT] = pin_sync_reg[PIN_PLUS_HI];
		irq_source_next[carkit_pkg::SRC_SESS_VALID_BIT] = pin_sync_reg[PIN_SESSION_VALID_FLAG];
		irq_source_next[carkit_pkg::SRC_BUS_VALID_BIT] = pin_sync_reg[PIN_BUS_VLD];
	end

	// read mux; unmapped addresses answer zero
	always_comb begin
		rd_valid_next = reg_rd_en;
		rdata_next = rdata_reg;
		if (reg_rd_en) begin
			case (reg_addr)
				carkit_pkg::ADDR_IRQ_SOURCE: begin
					rdata_next = irq_source_reg;
				end
				carkit_pkg::ADDR_OTG_SESSION_ID_STATE: begin
					rdata_next = otg_session_id_state_reg;
				end
				carkit_pkg::ADDR_RX_RECOVERY: begin
					rdata_next = rx_recovery_reg;
				end
				carkit_pkg::ADDR_IRQ_DETECT: begin
					rdata_next = carkit_irq_detect_value_reg;
				end
				default: begin
					rdata_next = 8'h00;
				end
			endcase
		end
	end

	// recovery output gated by the receive enable
	always_comb begin
		recovered_next = recovery_done && rx_pulse_en;
	end

	// register file; status loads from pins after reset
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rx_recovery_reg <= carkit_pkg::RX_RECOVERY_RESET;
			carkit_irq_detect_value_reg <= carkit_pkg::IRQ_DETECT_RESET;
			otg_session_id_state_reg <= 8'h00;
			irq_source_reg <= 8'h00;
			rdata_reg <= 8'h00;
			rd_valid_reg <= 1'b0;
			recovered_reg <= 1'b0;
		end else begin
			rx_recovery_reg <= rx_recovery_next;
			carkit_irq_detect_value_reg <= carkit_irq_detect_value_next;
			otg_session_id_state_reg <= otg_session_id_state_next;
			irq_source_reg <= irq_source_next;
			rdata_reg <= rdata_next;
			rd_valid_reg <= rd_valid_next;
			recovered_reg <= recovered_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign reg_rd_valid = rd_valid_reg;
	assign rx_polarity_recovered = recovered_reg;

	// reserved otg_session_id_state bits always read zero
	property p_reserved_zero;
		@(posedge ref_clk) disable iff (!rst_sync_n)
			otg_session_id_state_reg[7] == 1'b0 && otg_session_id_state_reg[5:4] == 2'h0 && otg_session_id_state_reg[0] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bit set");

	// power down clears the otg status flags and the id grounded source flag a cycle later
	property p_power_down;
		@(posedge ref_clk) disable iff (!rst_sync_n)
			power_down_mode |=> otg_session_id_state_reg == 8'h00 && !irq_source_reg[carkit_pkg::SRC_ID_GROUNDED_FLAG_BIT];
	endproperty
	a_power_down: assert property (p_power_down) else $error("flags live in power down");

	// session end flag follows its synchronised comparator
	property p_sess_end;
		@(posedge ref_clk) disable iff (!rst_sync_n)
			!power_down_mode |=> otg_session_id_state_reg[carkit_pkg::OTG_B_SESSION_END_FLAG_BIT] == $past(pin_sync_reg[PIN_SESS_END]);
	endproperty
	a_sess_end: assert property (p_sess_end) else $error("session end flag mismatch");

	// accessory flag is set one cycle after its synchronised comparator is set
	property p_accessory;
		@(posedge ref_clk) disable iff (!rst_sync_n)
			(!power_down_mode && pin_sync_reg[PIN_ID_ACCESSORY_FLAG])
				|=> otg_session_id_state_reg[carkit_pkg::OTG_ID_ACCESSORY_BIT];
	endproperty
	a_accessory: assert property (p_accessory) else $error("accessory flag missed");

	// charger resistor flags follow their comparators
	property p_charger;
		@(posedge ref_clk) disable iff (!rst_sync_n)
			!power_down_mode |=> otg_session_id_state_reg[2:1] == {$past(pin_sync_reg[PIN_ID_CHARGER_HIGH_R_FLAG]), $past(pin_sync_reg[PIN_ID_CHARGER_MID_R_FLAG])};
	endproperty
	a_charger: assert property (p_charger) else $error("charger flags mismatch");

	// lower source bits mirror the live signals
	property p_source_mirror;
		@(posedge ref_clk) disable iff (!rst_sync_n)
			1'b1 |=> irq_source_reg[2:0] == {$past(pin_sync_reg[PIN_PLUS_HI]), $past(pin_sync_reg[PIN_SESSION_VALID_FLAG]),
				$past(pin_sync_reg[PIN_BUS_VLD])};
	endproperty
	a_source_mirror: assert property (p_source_mirror) else $error("source bits not live");

	// a write to the recovery register is read back
	property p_recovery_write;
		@(posedge ref_clk) disable iff (!rst_sync_n)
			(reg_wr_en && reg_addr == carkit_pkg::ADDR_RX_RECOVERY) ##1 (reg_rd_en && !reg_wr_en
				&& reg_addr == carkit_pkg::ADDR_RX_RECOVERY) |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_recovery_write: assert property (p_recovery_write) else $error("recovery write lost");

	// a write to the detect register is stored
	property p_detect_write;
		@(posedge ref_clk) disable iff (!rst_sync_n)
			(reg_wr_en && reg_addr == carkit_pkg::ADDR_IRQ_DETECT) |=> carkit_irq_detect_value_reg == $past(reg_wdata);
	endproperty
	a_detect_write: assert property (p_detect_write) else $error("detect write lost");

	// recovery output stays low without receive enable
	property p_rx_gate;
		@(posedge ref_clk) disable iff (!rst_sync_n)
			!rx_pulse_en |=> !rx_polarity_recovered;
	endproperty
	a_rx_gate: assert property (p_rx_gate) else $error("recovery without receive enable");

	// every read is answered exactly one cycle later
	property p_read_answer;
		@(posedge ref_clk) disable iff (!rst_sync_n)
			reg_rd_en |=> reg_rd_valid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
endmodule

// ==== verilog/carkit_pkg.sv ====
// constants and types shared by the carkit status and timing registers
package carkit_pkg;
	// register offsets
	localparam logic [7:0] ADDR_IRQ_SOURCE = 8'h08;
	localparam logic [7:0] ADDR_OTG_SESSION_ID_STATE = 8'h10;
	localparam logic [7:0] ADDR_RX_RECOVERY = 8'h1E;
	localparam logic [7:0] ADDR_IRQ_DETECT = 8'h1F;
	// reset values of the timing registers
	localparam logic [7:0] RX_RECOVERY_RESET = 8'h64;
	localparam logic [7:0] IRQ_DETECT_RESET = 8'hC8;
	// otg_session_id_state field positions
	localparam int OTG_B_SESSION_END_FLAG_BIT = 6;
	localparam int OTG_ID_ACCESSORY_BIT = 3;
	localparam int OTG_ID_HIGH_R_BIT = 2;
	localparam int OTG_ID_MID_R_BIT = 1;
	// interrupt source field positions
	localparam int SRC_CARKIT_IRQ_BIT = 7;
	localparam int SRC_DISC_CONN_BIT = 6;
	localparam int SRC_ID_OPEN_BIT = 5;
	localparam int SRC_MINUS_HIGH_BIT = 4;
	localparam int SRC_ID_GROUNDED_FLAG_BIT = 3;
	localparam int SRC_PLUS_HIGH_BIT = 2;
	localparam int SRC_SESS_VALID_BIT = 1;
	localparam int SRC_BUS_VALID_BIT = 0;
	// timing: one tick of the timing registers
	localparam int TICK_TIME_NS = 250000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
	// number of pin level inputs that are synchronised
	localparam int PIN_COUNT = 12;
	// hold timer states, gray along idle, counting, detected
	typedef enum logic [1:0] {
		TIMER_IDLE = 2'h0,
		TIMER_COUNTING = 2'h1,
		TIMER_DETECTED = 2'h3
	} timer_state_type;
endpackage

// ==== verilog/low_hold_timer.sv ====
// detects a level held for a programmed number of ticks
`timescale 1ns/100ps
module low_hold_timer (
	input wire logic ref_clk,
	input wire logic rst_sync_n,
	input wire logic tick,
	input wire logic hold_level,
	input wire logic [7:0] limit,
	output logic detected
);
	carkit_pkg::timer_state_type state_reg; // timer state
	carkit_pkg::timer_state_type state_next;
	logic [7:0] cnt_reg; // ticks seen while level held
	logic [7:0] cnt_next;
	logic detected_reg; // registered detection
	logic detected_next;

	// next state; zero limit detects at once
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			carkit_pkg::TIMER_IDLE: begin
				cnt_next = 8'h00;
				if (hold_level) begin
					state_next = (limit == 8'h00) ? carkit_pkg::TIMER_DETECTED : carkit_pkg::TIMER_COUNTING;
				end
			end
			carkit_pkg::TIMER_COUNTING: begin
				if (!hold_level) begin
					// level released early
					state_next = carkit_pkg::TIMER_IDLE;
				end else if (tick) begin
					// compare elapsed ticks with the setting
					cnt_next = cnt_reg + 8'h01;
					if (cnt_next >= limit) begin
						state_next = carkit_pkg::TIMER_DETECTED;
					end
				end else if (cnt_reg >= limit) begin
					// setting lowered while counting
					state_next = carkit_pkg::TIMER_DETECTED;
				end
			end
			carkit_pkg::TIMER_DETECTED: begin
				if (!hold_level) begin
					state_next = carkit_pkg::TIMER_IDLE;
				end
			end
			default: begin
				state_next = carkit_pkg::TIMER_IDLE;
			end
		endcase
		detected_next = (state_next == carkit_pkg::TIMER_DETECTED);
	end

	// register the timer
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg <= carkit_pkg::TIMER_IDLE;
			cnt_reg <= 8'h00;
			detected_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			detected_reg <= detected_next;
		end
	end

	assign detected = detected_reg;

	// zero limit: a held level is flagged after one cycle
	property p_zero_limit;
		@(posedge ref_clk) disable iff (!rst_sync_n) (hold_level && limit == 8'h00) |=> detected_reg;
	endproperty
	a_zero_limit: assert property (p_zero_limit) else $error("zero limit not immediate");

	// releasing the level drops detection next cycle
	property p_release;
		@(posedge ref_clk) disable iff (!rst_sync_n) !hold_level |=> !detected_reg;
	endproperty
	a_release: assert property (p_release) else $error("detection outlived level");
endmodule

// ==== verilog/tick_divider.sv ====
// quarter millisecond tick generator
`timescale 1ns/100ps
module tick_divider #(
	parameter int TICK_CYCLES = carkit_pkg::TICK_CYCLES,
	parameter int CNT_WIDTH = 16
) (
	input wire logic ref_clk,
	input wire logic rst_sync_n,
	output logic tick
);
	logic [CNT_WIDTH-1:0] cnt_reg; // cycles since last tick
	logic [CNT_WIDTH-1:0] cnt_next;
	logic tick_reg; // one cycle tick pulse
	logic tick_next;
	localparam logic [CNT_WIDTH-1:0] LAST = CNT_WIDTH'(TICK_CYCLES - 1);

	// next count; wraps at the tick period
	always_comb begin
		tick_next = (cnt_reg == LAST);
		cnt_next = tick_next ? '0 : cnt_reg + 1'b1;
	end

	// register the divider
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;

	// a tick is a single cycle pulse
	property p_tick_single;
		@(posedge ref_clk) disable iff (!rst_sync_n) tick_reg |=> !tick_reg;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle");
endmodule
